// File: design/door_guard_pkg.sv
// constants and carrier types for the door-guard teach and status state machine
// Operation
// R1: taught actuator present, door closed, normal operation: both safety outputs on, door output high; code: at count 8 or more it enters teach-in.
// R2: normal operation, door open: safety outputs off, door output low, fault lamp dark.
// R3: delivery state, nothing taught: outputs off, status lamp flashes at 4 Hz.
// R4: successful teach-in turns status lamp off; operator removes supply 3 s to activate.
// R5: actuator leaves before 60 s: outputs off, fault lamp, status lamp flashes three times repeated.
// R6: power-up after sixth or seventh teach-in shows two or one flashes, outputs off.
// R7: teach count exhausted: power-up shows no teach-in possible, outputs off meanwhile.
// R8: ninth teach-in attempt with door closed: fault lamp, one flash repeated, outputs off.
// R9: teach-in of old actuator: fault lamp, two flashes repeated, outputs off.
// R10: internal, interference or output short fault: outputs off, fault lamp lit, any door position.
// R11: fault clears on guard open then close once cause removed; else power cycle.
// R12: two independent safety outputs plus one non-safety door monitoring output; code drives safety_output_b as a copy of safety_output_a.
// R13: teach-in with door closed flashes status lamp at 1 Hz, ends after 60 s.
// R14: completed teach-ins counted in non-volatile store, at most eight; last actuator only.
// R15: eighth teach-in done or old actuator: run 60 s cycle, keep stored code.
// R16: every state other than normal operation holds safety outputs off, door output low.
package door_guard_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int TEACH_S = 60;
   localparam longint TEACH_CYC = longint'(TEACH_S) * CLK_HZ;
   localparam int FAST_HZ = 4;
   localparam int SLOW_HZ = 1;
   localparam int FAST_HALF_CYC = CLK_HZ / (2 * FAST_HZ);
   localparam int SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_HZ);
   localparam int PULSE_HALF_CYC = CLK_HZ / 8;
   localparam int GAP_CYC = CLK_HZ;
   localparam logic [3:0] MAX_TEACH = 4'h8;
   localparam logic [3:0] SHOW_TWO_AT = 4'h6;
   localparam logic [3:0] SHOW_ONE_AT = 4'h7;
   localparam logic [1:0] PAT_NEG = 2'h3;
   localparam logic [1:0] PAT_NINTH = 2'h1;
   localparam logic [1:0] PAT_OLD = 2'h2;

   typedef enum logic [3:0] {
      ST_POWERUP = 4'h0,
      ST_DELIVERY = 4'h1,
      ST_SHOW = 4'h3,
      ST_NORMAL = 4'h2,
      ST_TEACH = 4'h6,
      ST_ACK = 4'h7,
      ST_OPFAULT = 4'h5,
      ST_FAULT = 4'h4
   } guard_state_t;

   typedef struct packed {
      logic actuator_present;
      logic actuator_taught;
      logic actuator_old;
      logic door_closed;
   } sense_t;

   typedef struct packed {
      logic internal_fault;
      logic interference;
      logic output_short;
   } fault_in_t;

   typedef struct packed {
      logic safety_output_a;
      logic safety_output_b;
      logic door_monitor;
      logic status_lamp;
      logic fault_lamp;
      logic actuator_lamp;
   } outs_t;
endpackage : door_guard_pkg

// File: design/door_guard_teach_status_fsm.sv
// door-guard state machine: safety outputs, door monitor and lamps
`timescale 1ns/1ns
module door_guard_teach_status_fsm #(
   parameter longint TEACH_CYCLES = door_guard_pkg::TEACH_CYC
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire door_guard_pkg::sense_t sense,
   input wire door_guard_pkg::fault_in_t fault_in,
   input wire logic [3:0] teach_count_nv,
   output door_guard_pkg::outs_t outs,
   output logic teach_count_inc,
   output logic learn_code
);
   import door_guard_pkg::*;

   guard_state_t state_q, state_d;
   logic [35:0] timer_q, timer_d;
   logic [27:0] blink_q;
   logic blink_ph_q;
   logic [2:0] pulse_q;
   logic [1:0] pat_q, pat_d;
   logic door_seen_open_q;
   logic keep_code_q, keep_code_d;
   outs_t outs_d;

   function automatic logic any_fault(input fault_in_t f);
      any_fault = f.internal_fault | f.interference | f.output_short;
   endfunction : any_fault

   wire hard_fault = any_fault(fault_in);
   wire timer_done = (timer_q >= 36'(TEACH_CYCLES - 1));
   wire exhausted = (teach_count_nv >= MAX_TEACH);
   wire teach_start = sense.door_closed & sense.actuator_present
                      & (~sense.actuator_taught | sense.actuator_old | exhausted);
   // repeated pulse patterns: n pulses then a gap, counted on the PULSE_HALF_CYC tick
   wire [27:0] half_len = (state_q == ST_DELIVERY) ? 28'(FAST_HALF_CYC)
                        : (state_q == ST_TEACH) ? 28'(SLOW_HALF_CYC) : 28'(PULSE_HALF_CYC);
   wire blink_tick = (blink_q >= half_len - 28'h1);
   // with no teach-in left the lamp stays dark: zero pulses, only the gap step runs
   wire [1:0] pat_now = (state_q != ST_SHOW) ? pat_q
                        : (teach_count_nv == SHOW_TWO_AT) ? 2'h2
                        : (teach_count_nv == SHOW_ONE_AT) ? 2'h1 : 2'h0; // R6 R7
   wire [2:0] pat_steps = {pat_now, 1'b0} + 3'h1;
   wire pulse_lamp = (pulse_q < {pat_now, 1'b0}) & ~pulse_q[0];

   always_comb begin
      state_d = state_q;
      timer_d = '0;
      pat_d = pat_q;
      keep_code_d = keep_code_q;
      case (state_q)
         ST_POWERUP: begin
            if (!sense.actuator_taught && teach_count_nv == 4'h0)
               state_d = ST_DELIVERY; // R3
            else if (teach_count_nv >= SHOW_TWO_AT)
               state_d = ST_SHOW; // R6 R7
            else
               state_d = ST_NORMAL;
         end
         ST_DELIVERY: begin
            if (teach_start) begin
               state_d = ST_TEACH;
               keep_code_d = 1'b0;
            end
         end
         ST_SHOW: begin
            timer_d = timer_q + 36'h1;
            if (timer_q[27:0] >= 28'(GAP_CYC) * 28'h2)
               state_d = ST_NORMAL;
         end
         ST_NORMAL: begin
            if (teach_start) begin
               state_d = ST_TEACH; // R15
               keep_code_d = exhausted | sense.actuator_old; // R15
            end
         end
         ST_TEACH: begin
            timer_d = timer_q + 36'h1;
            if (!sense.door_closed || !sense.actuator_present) begin
               state_d = ST_OPFAULT; // R5
               pat_d = PAT_NEG;
            end else if (timer_done) begin // R13
               if (keep_code_q) begin
                  state_d = ST_OPFAULT;
                  pat_d = exhausted ? PAT_NINTH : PAT_OLD; // R8 R9
               end else
                  state_d = ST_ACK; // R4
            end
         end
         ST_ACK: state_d = ST_ACK; // R4 waits for the operator's power cycle
         ST_OPFAULT: state_d = ST_OPFAULT;
         ST_FAULT: begin
            if (door_seen_open_q && sense.door_closed)
               state_d = ST_NORMAL; // R11
         end
         default: state_d = ST_POWERUP;
      endcase
      if (hard_fault)
         state_d = ST_FAULT; // R10
   end

   always_comb begin
      outs_d = '0; // R16
      outs_d.actuator_lamp = sense.actuator_present & sense.actuator_taught;
      case (state_q)
         ST_NORMAL: begin
            outs_d.safety_output_a = sense.door_closed & sense.actuator_present
                                     & sense.actuator_taught; // R1 R12
            outs_d.safety_output_b = outs_d.safety_output_a; // R12
            outs_d.door_monitor = outs_d.safety_output_a; // R1 R2
            outs_d.status_lamp = 1'b1;
         end
         ST_DELIVERY: outs_d.status_lamp = blink_ph_q; // R3
         ST_TEACH: outs_d.status_lamp = blink_ph_q; // R13
         ST_ACK: outs_d.status_lamp = 1'b0; // R4
         ST_SHOW: outs_d.status_lamp = pulse_lamp; // R6
         ST_OPFAULT: begin
            outs_d.status_lamp = pulse_lamp; // R5 R8 R9
            outs_d.fault_lamp = 1'b1;
         end
         ST_FAULT: outs_d.fault_lamp = 1'b1; // R10
         default: outs_d = '0;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_POWERUP;
         timer_q <= '0;
         pat_q <= '0;
         keep_code_q <= 1'b0;
         outs <= '0;
      end else begin
         state_q <= state_d;
         timer_q <= timer_d;
         pat_q <= pat_d;
         keep_code_q <= keep_code_d;
         outs <= outs_d;
      end
   end

   // lamp timebase; the gap step also ends on the half-period tick, so it is no longer than a pulse step
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         blink_q <= '0;
         blink_ph_q <= 1'b0;
         pulse_q <= '0;
      end else if (state_q != state_d) begin
         blink_q <= '0;
         blink_ph_q <= 1'b0;
         pulse_q <= '0;
      end else if (blink_tick || (pulse_q == pat_steps - 3'h1 && blink_q >= 28'(GAP_CYC))) begin
         blink_q <= '0;
         blink_ph_q <= ~blink_ph_q;
         pulse_q <= (pulse_q >= pat_steps - 3'h1) ? 3'h0 : pulse_q + 3'h1;
      end else
         blink_q <= blink_q + 28'h1;
   end

   // count a completed teach-in once; store the new code unless the old one is kept
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         teach_count_inc <= 1'b0;
         learn_code <= 1'b0;
      end else begin
         teach_count_inc <= (state_q == ST_TEACH) && (state_d == ST_ACK); // R14
         learn_code <= (state_q == ST_TEACH) && (state_d == ST_ACK) && !keep_code_q; // R14 R15
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         door_seen_open_q <= 1'b0;
      else if (state_q != ST_FAULT)
         door_seen_open_q <= 1'b0;
      else if (!sense.door_closed && !hard_fault)
         door_seen_open_q <= 1'b1; // R11
   end

   sequence seq_teach_leave;
      state_q == ST_TEACH && !hard_fault && !sense.door_closed;
   endsequence

   sequence seq_teach_full;
      state_q == ST_TEACH && timer_done && sense.door_closed && sense.actuator_present
      && !hard_fault;
   endsequence

   sequence seq_show_enter;
      state_q == ST_POWERUP && !hard_fault
      && (teach_count_nv == SHOW_TWO_AT || teach_count_nv == SHOW_ONE_AT);
   endsequence

   sequence seq_show_hold;
      state_q == ST_SHOW && !hard_fault
      && (teach_count_nv == SHOW_TWO_AT || teach_count_nv == SHOW_ONE_AT);
   endsequence

   sequence seq_normal_teach;
      state_q == ST_NORMAL && teach_start && !hard_fault;
   endsequence

   sequence seq_fault_clear;
      state_q == ST_FAULT && door_seen_open_q && sense.door_closed && !hard_fault;
   endsequence

   AST_POWERUP_LEAVES: assert property (@(posedge ref_clk) disable iff (rst) // R16
      state_q == ST_POWERUP |=> state_q != ST_POWERUP)
      else $error("power-up state did not resolve");
   AST_DELIVERY_ENTRY: assert property (@(posedge ref_clk) disable iff (rst) // R3
      state_q == ST_POWERUP && !hard_fault && !sense.actuator_taught && teach_count_nv == 4'h0
      |=> state_q == ST_DELIVERY)
      else $error("delivery state not entered");
   AST_SHOW_ENTRY: assert property (@(posedge ref_clk) disable iff (rst) // R6
      state_q == ST_POWERUP && !hard_fault && teach_count_nv >= SHOW_TWO_AT
      |=> state_q == ST_SHOW)
      else $error("remaining count not shown");
   AST_SHOW_FIRST_FLASH: assert property (@(posedge ref_clk) disable iff (rst) // R6
      seq_show_enter ##1 seq_show_hold |=> outs.status_lamp)
      else $error("count display did not start with a flash");
   AST_EXHAUSTED_DARK: assert property (@(posedge ref_clk) disable iff (rst) // R7
      state_q == ST_SHOW && teach_count_nv >= MAX_TEACH |=> !outs.status_lamp)
      else $error("status lamp lit with no teach-in left");
   AST_DELIVERY_TEACH: assert property (@(posedge ref_clk) disable iff (rst) // R13
      state_q == ST_DELIVERY && teach_start && !hard_fault
      |=> state_q == ST_TEACH && !keep_code_q)
      else $error("first teach-in not started");
   AST_KEEP_CODE: assert property (@(posedge ref_clk) disable iff (rst) // R15
      seq_normal_teach ##0 (exhausted || sense.actuator_old)
      |=> state_q == ST_TEACH && keep_code_q)
      else $error("stored code not kept");
   AST_TEACH_SAFE: assert property (@(posedge ref_clk) disable iff (rst) // R13
      state_q == ST_TEACH
      |=> !outs.safety_output_a && !outs.door_monitor && !outs.fault_lamp)
      else $error("outputs on during teach-in");
   AST_TEACH_BOUND: assert property (@(posedge ref_clk) disable iff (rst) // R13
      state_q == ST_TEACH |-> timer_q < 36'(TEACH_CYCLES))
      else $error("teach-in overran its interval");
   AST_TEACH_DONE_ACK: assert property (@(posedge ref_clk) disable iff (rst) // R4
      seq_teach_full ##0 !keep_code_q |=> state_q == ST_ACK)
      else $error("completed teach-in not acknowledged");
   AST_NINTH_PAT: assert property (@(posedge ref_clk) disable iff (rst) // R8
      seq_teach_full ##0 (keep_code_q && exhausted)
      |=> state_q == ST_OPFAULT && pat_q == PAT_NINTH)
      else $error("ninth teach-in not refused");
   AST_OLD_PAT: assert property (@(posedge ref_clk) disable iff (rst) // R9
      seq_teach_full ##0 (keep_code_q && !exhausted)
      |=> state_q == ST_OPFAULT && pat_q == PAT_OLD)
      else $error("old actuator not refused");
   AST_INC_ON_ACK: assert property (@(posedge ref_clk) disable iff (rst) // R14
      state_q == ST_TEACH ##1 state_q == ST_ACK |-> teach_count_inc)
      else $error("completed teach-in not counted");
   AST_NO_LEARN_KEPT: assert property (@(posedge ref_clk) disable iff (rst) // R15
      learn_code |-> state_q == ST_ACK && !keep_code_q)
      else $error("code stored while old code kept");
   AST_OPFAULT_LAMP: assert property (@(posedge ref_clk) disable iff (rst) // R5
      state_q == ST_OPFAULT |=> outs.fault_lamp && !outs.safety_output_a)
      else $error("operating fault not shown");
   AST_OPFAULT_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // R8
      state_q == ST_OPFAULT && !hard_fault |=> state_q == ST_OPFAULT)
      else $error("operating fault left without power cycle");
   AST_ACK_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // R4
      state_q == ST_ACK && !hard_fault |=> state_q == ST_ACK)
      else $error("acknowledgment left without power cycle");
   AST_FAULT_LAMP: assert property (@(posedge ref_clk) disable iff (rst) // R10
      state_q == ST_FAULT |=> outs.fault_lamp && !outs.safety_output_b)
      else $error("fault state drove outputs");
   AST_FAULT_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // R11
      state_q == ST_FAULT && !door_seen_open_q |=> state_q == ST_FAULT)
      else $error("fault cleared without door opening");
   AST_SEEN_OPEN: assert property (@(posedge ref_clk) disable iff (rst) // R11
      state_q == ST_FAULT && !sense.door_closed && !hard_fault |=> door_seen_open_q)
      else $error("door opening not noted in fault");
   AST_FAULT_CLEAR: assert property (@(posedge ref_clk) disable iff (rst) // R11
      seq_fault_clear |=> state_q == ST_NORMAL)
      else $error("fault not cleared by door cycle");

   AST_SAFE_OFF_OUTSIDE_NORMAL: assert property (@(posedge ref_clk) disable iff (rst) // R16
      state_q != ST_NORMAL |=> !outs.safety_output_a && !outs.safety_output_b
                               && !outs.door_monitor)
      else $error("safety outputs on outside normal operation");
   AST_NORMAL_CLOSED_ON: assert property (@(posedge ref_clk) disable iff (rst) // R1
      state_q == ST_NORMAL && sense.door_closed && sense.actuator_present
      && sense.actuator_taught |=> outs.safety_output_a && outs.door_monitor)
      else $error("closed door did not enable outputs");
   AST_NORMAL_OPEN_OFF: assert property (@(posedge ref_clk) disable iff (rst) // R2
      state_q == ST_NORMAL && !sense.door_closed |=> !outs.door_monitor && !outs.fault_lamp)
      else $error("open door left outputs or fault lamp on");
   AST_OUTPUTS_PAIRED: assert property (@(posedge ref_clk) disable iff (rst) // R12
      outs.safety_output_a == outs.safety_output_b)
      else $error("safety outputs disagree");
   AST_HARD_FAULT: assert property (@(posedge ref_clk) disable iff (rst) // R10
      hard_fault |=> state_q == ST_FAULT ##1 outs.fault_lamp && !outs.safety_output_a)
      else $error("hard fault not taken");
   AST_NEG_ACK: assert property (@(posedge ref_clk) disable iff (rst) // R5
      seq_teach_leave |=> state_q == ST_OPFAULT && pat_q == PAT_NEG)
      else $error("early actuator removal not refused");
   AST_ACK_DARK: assert property (@(posedge ref_clk) disable iff (rst) // R4
      state_q == ST_ACK && !hard_fault |=> !outs.status_lamp)
      else $error("status lamp lit after acknowledgment");
   AST_DELIVERY_SAFE: assert property (@(posedge ref_clk) disable iff (rst) // R3
      state_q == ST_DELIVERY [*2] |-> !outs.safety_output_a && !outs.fault_lamp)
      else $error("delivery state drove outputs");
   AST_COUNT_ONCE: assert property (@(posedge ref_clk) disable iff (rst) // R14
      teach_count_inc |=> !teach_count_inc && $past(state_q) == ST_ACK)
      else $error("teach count pulse wrong");
endmodule : door_guard_teach_status_fsm

// File: verification/plc_model.sv
// safety control model that enables the machine from both safety outputs
`timescale 1ns/1ns
module plc_model (
   input wire door_guard_pkg::outs_t outs,
   output logic run_ok
);
   import door_guard_pkg::*;
   // one channel alone never enables, so a stuck output shows as a lost run
   // the door monitor is ignored here: it is status only, never a safety channel
   assign run_ok = outs.safety_output_a & outs.safety_output_b;
endmodule : plc_model

// File: verification/test_door_guard_teach_status_fsm.sv
// self-checking bench for the door-guard state machine
`timescale 1ns/1ns
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module test_door_guard_teach_status_fsm;
   import door_guard_pkg::*;
   // short teach cycle keeps the run small; expectations follow from it
   localparam longint TC = 200;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   sense_t sense = 4'h0;
   fault_in_t fault_in = 3'h0;
   logic [3:0] teach_count_nv = 4'h0;
   outs_t outs;
   logic teach_count_inc;
   logic learn_code;
   logic run_ok;
   int n_mismatch = 0;
   int samples_checked = 0;
   int n_inc = 0;
   int n_learn = 0;

   door_guard_teach_status_fsm #(.TEACH_CYCLES(TC)) uut (
      .ref_clk(ref_clk), .rst(rst), .sense(sense), .fault_in(fault_in),
      .teach_count_nv(teach_count_nv), .outs(outs), .teach_count_inc(teach_count_inc),
      .learn_code(learn_code));
   plc_model plc (.outs(outs), .run_ok(run_ok));

   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (teach_count_inc === 1'b1) n_inc++;
      if (learn_code === 1'b1) n_learn++;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : cyc
   // power cycle: reset stands in for the supply being removed
   task automatic power(input sense_t s, input logic [3:0] cnt);
      rst = 1'b1;
      sense = s;
      fault_in = 3'h0;
      teach_count_nv = cnt;
      cyc(5);
      n_inc = 0;
      n_learn = 0;
      rst = 1'b0;
      cyc(6);
   endtask : power
   task automatic check_off();
      `CHK({outs.safety_output_a, outs.safety_output_b, outs.door_monitor, run_ok}, 4'h0)
   endtask : check_off

   task automatic t_normal();
      power(4'hD, 4'h1);
      `CHK({outs.safety_output_a, outs.safety_output_b, outs.door_monitor}, 3'h7)
      `CHK(run_ok, 1'b1)
      sense = 4'hC;
      cyc(4);
      `CHK({outs.safety_output_a, outs.safety_output_b, outs.door_monitor, outs.fault_lamp},
         4'h0)
   endtask : t_normal

   task automatic t_fault();
      for (int i = 0; i < 3; i++) begin
         power((i == 1) ? 4'hC : 4'hD, 4'h1);
         fault_in = 3'h1 << i;
         cyc(3);
         `CHK({outs.safety_output_a, outs.safety_output_b, outs.fault_lamp}, 3'h1)
      end
      fault_in = 3'h0;
      cyc(4);
      `CHK(outs.fault_lamp, 1'b1)
      sense = 4'hC;
      cyc(4);
      sense = 4'hD;
      cyc(6);
      `CHK({outs.safety_output_a, outs.safety_output_b, outs.fault_lamp}, 3'h6)
   endtask : t_fault

   task automatic t_teach(input sense_t s, input logic [3:0] cnt, input int inc, input logic flt);
      power(s, cnt);
      cyc(50);
      check_off();
      cyc(int'(TC) + 10);
      `CHK(n_inc, inc)
      `CHK(n_learn, inc)
      `CHK(outs.fault_lamp, flt)
      if (flt === 1'b0) `CHK(outs.status_lamp, 1'b0)
      check_off();
   endtask : t_teach

   task automatic t_neg_ack();
      power(4'h9, 4'h1);
      cyc(50);
      sense = 4'h8;
      cyc(5);
      `CHK({outs.safety_output_a, outs.safety_output_b, outs.fault_lamp}, 3'h1)
      cyc(int'(TC));
      `CHK(n_inc, 0)
   endtask : t_neg_ack

   // ninth attempt: leave the count display through a fault cycle, then teach again
   task automatic t_ninth();
      power(4'hD, 4'h8);
      fault_in = 3'h4;
      cyc(3);
      fault_in = 3'h0;
      sense = 4'hC;
      cyc(3);
      sense = 4'hD;
      cyc(50);
      check_off();
      cyc(int'(TC) + 10);
      `CHK(n_inc, 0)
      `CHK(n_learn, 0)
      `CHK(outs.fault_lamp, 1'b1)
      check_off();
   endtask : t_ninth

   task automatic t_show();
      power(4'h8, 4'h0);
      check_off();
      `CHK(outs.fault_lamp, 1'b0)
      power(4'hD, 4'h6);
      check_off();
      `CHK(outs.status_lamp, 1'b1)
      power(4'hD, 4'h7);
      check_off();
      `CHK(outs.status_lamp, 1'b1)
      power(4'hD, 4'h8);
      check_off();
      `CHK(outs.status_lamp, 1'b0)
   endtask : t_show

   task automatic print_verdict();
      if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : print_verdict

   // the tests need about 1200 cycles; ten thousand means a hang
   initial begin
      #100_000;
      n_mismatch++;
      print_verdict();
   end
   initial begin
      t_normal();
      t_fault();
      t_teach(4'h9, 4'h0, 1, 1'b0);
      t_teach(4'hB, 4'h2, 0, 1'b1);
      t_neg_ack();
      t_ninth();
      t_show();
      print_verdict();
   end
endmodule : test_door_guard_teach_status_fsm
